// [hdl/timer_irq_pkg.sv]
// Constants for the timer interrupt flag and mask block
// How it works
// RQ1 - Enabled extended flag with global enable raises its timer interrupt request.
// RQ2 - Extended enable bits: t3 capture 5, A 4, B 3, ovf 2, C 1, t1 C 0.
// RQ3 - Software writes zeros to extended enable bits 7:6.
// RQ4 - In legacy compatibility mode the extended enable register is not reachable.
// RQ5 - Shared flags: t1 capture 5, A 4, B 3, overflow 2; reset to zero.
// RQ6 - First timer capture flag sets on a capture event at its pin.
// RQ7 - Third timer capture flag sets on a capture event at its pin.
// RQ8 - With capture register as ceiling, capture flag sets when counter reaches it.
// RQ9 - Capture flag clears on vector execution or software writing one.
// RQ10 - Compare A/B flags set the timer clock cycle after counter equals compare.
// RQ11 - Forced compare strobes never set compare flags.
// RQ12 - Compare flags clear on vector execution or software writing one.
// RQ13 - Overflow flag set on overflow in normal/clear-on-match; else per mode.
// RQ14 - First timer overflow flag clears on vector or software writing one.
// RQ15 - Extended flags: t3 capture 5, compare A 4, compare B 3.
// RQ16 - Software writes zeros to extended flag bits 7:6.
// RQ17 - Extended flags: t3 overflow 2, t3 compare C 1, t1 compare C 0.
// RQ18 - Writing zero leaves flags; request only when flag, enable, global set.
package timer_irq_pkg;
    localparam int         DATA_W        = 32;
    localparam int         ADDR_W        = 8;
    localparam int         REG_W         = 8;
    localparam int         NSRC          = 6;
    // Register byte addresses
    localparam logic [7:0] ADDR_T_EN     = 8'h00;
    localparam logic [7:0] ADDR_T_FLAGS  = 8'h04;
    localparam logic [7:0] ADDR_X_EN     = 8'h08;
    localparam logic [7:0] ADDR_X_FLAGS  = 8'h0C;
    localparam logic [7:0] ADDR_CTRL     = 8'h10;
    // Bit positions, shared by enable and flag registers; B_GIE and B_LEGACY are control register bits
    localparam int         B_CAP         = 5;
    localparam int         B_CMP_A       = 4;
    localparam int         B_CMP_B       = 3;
    localparam int         B_OVF         = 2;
    localparam int         B_T3_CMP_C    = 1;
    localparam int         B_T1_CMP_C    = 0;
    localparam int         B_GIE         = 0;
    localparam int         B_LEGACY      = 1;
    localparam logic [5:0] SRC_RESET     = 6'h00;
    // Only capture, compare A/B and overflow of the first timer live in the shared register
    localparam logic [5:0] T1_FLAG_MASK  = 6'h3C;
    localparam logic [1:0] RESP_OKAY     = 2'b00;
    localparam logic [1:0] RESP_SLVERR   = 2'b10;
    localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
endpackage

// [hdl/timer_irq_flag_mask.sv]
// Timer interrupt flags, masks and AXI4-Lite register slave
`timescale 1ns/10ps
module timer_irq_flag_mask
    import timer_irq_pkg::*;
(
    // Clock and reset
    input  wire logic                          ref_clk_i,
    input  wire logic                          nrst_i,
    input  wire logic                          clk_en_i,
    // AXI4-Lite write address, data and response
    input  wire logic [timer_irq_pkg::ADDR_W-1:0] awaddr_i,
    input  wire logic                          awvalid_i,
    output logic                               awready_o,
    input  wire logic [timer_irq_pkg::DATA_W-1:0] wdata_i,
    input  wire logic [3:0]                    wstrb_i,
    input  wire logic                          wvalid_i,
    output logic                               wready_o,
    output logic [1:0]                         bresp_o,
    output logic                               bvalid_o,
    input  wire logic                          bready_i,
    // AXI4-Lite read
    input  wire logic [timer_irq_pkg::ADDR_W-1:0] araddr_i,
    input  wire logic                          arvalid_i,
    output logic                               arready_o,
    output logic [timer_irq_pkg::DATA_W-1:0]   rdata_o,
    output logic [1:0]                         rresp_o,
    output logic                               rvalid_o,
    input  wire logic                          rready_i,
    // Timer events, one-cycle pulses per timer clock tick; t1_top_is_capture_i and t3_top_is_capture_i are mode levels
    input  wire logic                          t1_capture_pin_evt_i,
    input  wire logic                          t3_capture_pin_evt_i,
    input  wire logic                          t1_top_is_capture_i,
    input  wire logic                          t3_top_is_capture_i,
    input  wire logic                          t1_reach_top_i,
    input  wire logic                          t3_reach_top_i,
    input  wire logic [2:0]                    t1_cmp_equal_i,
    input  wire logic [2:0]                    t3_cmp_equal_i,
    input  wire logic                          t1_overflow_evt_i,
    input  wire logic                          t3_overflow_evt_i,
    // Vector execution acknowledges
    input  wire logic [5:0]                    t1_vector_ack_i,
    input  wire logic [5:0]                    t3_vector_ack_i,
    // Requests to the core
    output logic [5:0]                         t1_irq_req_o,
    output logic [5:0]                         t3_irq_req_o,
    output logic                               irq_o
);
    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic [5:0]             t1_en;
        logic [5:0]             x_en;
        logic [5:0]             t1_flags;
        logic [5:0]             x_flags;
        logic                   gie;
        logic                   legacy;
        logic                   aw_held;
        logic [ADDR_W-1:0]      aw_addr;
        logic                   w_held;
        logic [DATA_W-1:0]      w_data;
        logic [3:0]             w_strb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [1:0]             rresp;
        logic [DATA_W-1:0]      rdata;
    } state_s;

    state_s st;
    state_s next_st;

    // Address decode; extended enable vanishes in legacy mode
    function automatic logic mapped(input logic [ADDR_W-1:0] a, input logic legacy);
        mapped = (a == ADDR_T_EN) || (a == ADDR_T_FLAGS) || (a == ADDR_X_FLAGS) ||
                 (a == ADDR_CTRL) || ((a == ADDR_X_EN) && !legacy); // RQ4
    endfunction

    // Flag update: set beats every clear
    function automatic logic [5:0] upd(input logic [5:0] f, input logic [5:0] set,
                                       input logic [5:0] clr);
        upd = (f & ~clr) | set; // RQ18
    endfunction

    logic [5:0] t1_set;
    logic [5:0] x_set;
    logic       do_wr;
    logic [5:0] w1c_t1;
    logic [5:0] w1c_x;
    logic       wr_ok;

    // --------------------------------------------------------------
    // Event decode
    // --------------------------------------------------------------
    always_comb
    begin
        t1_set = SRC_RESET;
        x_set  = SRC_RESET;
        // Capture pin ignored when capture register is top
        t1_set[B_CAP] = t1_top_is_capture_i ? t1_reach_top_i : t1_capture_pin_evt_i; // RQ6 RQ8
        x_set[B_CAP]  = t3_top_is_capture_i ? t3_reach_top_i : t3_capture_pin_evt_i; // RQ7 RQ8
        // Equality pulses come from the timer, never forced strobes
        t1_set[B_CMP_A] = t1_cmp_equal_i[0]; // RQ10 RQ11
        t1_set[B_CMP_B] = t1_cmp_equal_i[1]; // RQ10 RQ11
        t1_set[B_OVF]   = t1_overflow_evt_i; // RQ13
        x_set[B_CMP_A]      = t3_cmp_equal_i[0]; // RQ10 RQ11
        x_set[B_CMP_B]      = t3_cmp_equal_i[1]; // RQ10 RQ11
        x_set[B_OVF]        = t3_overflow_evt_i; // RQ17
        x_set[B_T3_CMP_C]   = t3_cmp_equal_i[2]; // RQ17
        x_set[B_T1_CMP_C]   = t1_cmp_equal_i[2]; // RQ17
    end

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        do_wr   = st.aw_held && st.w_held && !st.bvalid;
        wr_ok   = mapped(st.aw_addr, st.legacy);
        w1c_t1  = SRC_RESET;
        w1c_x   = SRC_RESET;

        if (awvalid_i && !st.aw_held)
        begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = awaddr_i;
        end
        if (wvalid_i && !st.w_held)
        begin
            next_st.w_held = 1'b1;
            next_st.w_data = wdata_i;
            next_st.w_strb = wstrb_i;
        end

        if (do_wr)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
            if (wr_ok && st.w_strb[0])
            begin
                unique case (st.aw_addr)
                    ADDR_T_EN:    next_st.t1_en = st.w_data[5:0];
                    ADDR_X_EN:    next_st.x_en  = st.w_data[5:0]; // RQ2 RQ3
                    ADDR_T_FLAGS: w1c_t1 = st.w_data[5:0]; // RQ9 RQ12 RQ14
                    ADDR_X_FLAGS: w1c_x  = st.w_data[5:0]; // RQ9 RQ12 RQ16
                    ADDR_CTRL:
                    begin
                        next_st.gie    = st.w_data[B_GIE];
                        next_st.legacy = st.w_data[B_LEGACY];
                    end
                    default:      next_st.bresp = RESP_SLVERR;
                endcase
            end
        end
        if (st.bvalid && bready_i)
        begin
            next_st.bvalid = 1'b0;
        end

        // Reads: extended enable gone in legacy mode
        if (arvalid_i && !st.rvalid)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = mapped(araddr_i, st.legacy) ? RESP_OKAY : RESP_SLVERR; // RQ4
            next_st.rdata  = ZERO_WORD;
            unique case (araddr_i)
                ADDR_T_EN:    next_st.rdata[5:0] = st.t1_en;
                ADDR_X_EN:    next_st.rdata[5:0] = st.legacy ? SRC_RESET : st.x_en; // RQ4
                ADDR_T_FLAGS: next_st.rdata[5:0] = st.t1_flags; // RQ5
                ADDR_X_FLAGS: next_st.rdata[5:0] = st.x_flags; // RQ15 RQ17
                ADDR_CTRL:
                begin
                    next_st.rdata[B_GIE]    = st.gie;
                    next_st.rdata[B_LEGACY] = st.legacy;
                end
                default:      next_st.rdata = ZERO_WORD;
            endcase
        end
        else if (st.rvalid && rready_i)
        begin
            next_st.rvalid = 1'b0;
        end

        // Only the shared register's first-timer bits live here
        next_st.t1_flags = upd(st.t1_flags, t1_set & T1_FLAG_MASK,
                               (w1c_t1 | t1_vector_ack_i) & T1_FLAG_MASK); // RQ5 RQ9 RQ12 RQ14
        next_st.x_flags  = upd(st.x_flags, x_set, w1c_x | t3_vector_ack_i); // RQ9 RQ12 RQ17
    end

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            st <= '0;
        end
        else if (clk_en_i)
        begin
            st <= next_st;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign awready_o    = !st.aw_held;
    assign wready_o     = !st.w_held;
    assign bvalid_o     = st.bvalid;
    assign bresp_o      = st.bresp;
    assign arready_o    = !st.rvalid;
    assign rvalid_o     = st.rvalid;
    assign rresp_o      = st.rresp;
    assign rdata_o      = st.rdata;
    assign t1_irq_req_o = st.gie ? (st.t1_flags & st.t1_en) : SRC_RESET; // RQ18
    assign t3_irq_req_o = st.gie ? (st.x_flags & st.x_en) : SRC_RESET; // RQ1 RQ18
    assign irq_o        = |t1_irq_req_o || |t3_irq_req_o;

endmodule // timer_irq_flag_mask

// [bench/cpu_core_model.sv]
// Core model that runs one pending timer vector at a time
`timescale 1ns/10ps
module cpu_core_model
(
    input  wire logic       ref_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       ack_en_i,
    input  wire logic [5:0] t1_irq_req_i,
    input  wire logic [5:0] t3_irq_req_i,
    output logic      [5:0] t1_vector_ack_o,
    output logic      [5:0] t3_vector_ack_o
);
    // Lowest request of the first timer wins; a gap cycle lets the flag drop
    always_ff @(posedge ref_clk_i)
    begin
        if (!nrst_i || !ack_en_i || (t1_vector_ack_o != 6'h00) || (t3_vector_ack_o != 6'h00))
        begin
            t1_vector_ack_o <= 6'h00;
            t3_vector_ack_o <= 6'h00;
        end
        else
        begin
            t1_vector_ack_o <= t1_irq_req_i & (~t1_irq_req_i + 6'h01);
            t3_vector_ack_o <= (t1_irq_req_i != 6'h00) ? 6'h00 : t3_irq_req_i & (~t3_irq_req_i + 6'h01);
        end
    end
endmodule // cpu_core_model

// [bench/timer_irq_checker.sv]
// Concurrent checks on the timer interrupt block ports
`timescale 1ns/10ps
module timer_irq_checker
    import timer_irq_pkg::*;
(
    input wire logic              ref_clk_i, nrst_i, clk_en_i, awvalid_i, awready_o, wvalid_i, wready_o,
    input wire logic              bvalid_o, arvalid_i, arready_o, rvalid_o, rready_i, irq_o,
    input wire logic              t3_top_is_capture_i, t3_overflow_evt_i, t3_capture_pin_evt_i, t3_reach_top_i,
    input wire logic [2:0]        t1_cmp_equal_i,
    input wire logic [5:0]        t1_irq_req_o, t3_irq_req_o, t1_vector_ack_i, t3_vector_ack_i,
    input wire logic [DATA_W-1:0] rdata_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    req_or_a: assert property (irq_o == ((|t1_irq_req_o) || (|t3_irq_req_o)))
        else $error("irq_o differs from OR of requests");
    spare_req_a: assert property (t1_irq_req_o[1:0] == 2'b00)
        else $error("unused first timer request bits set");
    wr_resp_a: assert property (awvalid_i && awready_o && wvalid_i && wready_o |=> ##[0:1] bvalid_o)
        else $error("write response late");
    rd_lat_a: assert property (arvalid_i && arready_o |=> rvalid_o)
        else $error("read data late");
    rd_hold_a: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
        else $error("read data not held");
    ovf_cause_a: assert property ($rose(t3_irq_req_o[B_OVF]) |-> $past(t3_overflow_evt_i) || bvalid_o)
        else $error("overflow request without cause");
    cmp_cause_a: assert property ($rose(t1_irq_req_o[B_CMP_A]) |-> $past(t1_cmp_equal_i[0]) || bvalid_o)
        else $error("compare request without match");
    flag_sticky_a: assert property (clk_en_i && t1_irq_req_o[B_CAP] && !t1_vector_ack_i[B_CAP]
        && awready_o && !awvalid_i |=> t1_irq_req_o[B_CAP]) else $error("capture flag lost");
    ack_clear_a: assert property (clk_en_i && t3_vector_ack_i[B_CAP] && !t3_capture_pin_evt_i
        && !t3_reach_top_i |=> !t3_irq_req_o[B_CAP]) else $error("vector did not clear flag");
    top_mode_a: assert property (clk_en_i && t3_top_is_capture_i && !t3_reach_top_i && !t3_irq_req_o[B_CAP]
        && awready_o && !awvalid_i |=> !t3_irq_req_o[B_CAP]) else $error("pin set flag in top mode");
    freeze_hold_a: assert property (!clk_en_i |=> $stable(t1_irq_req_o) && $stable(t3_irq_req_o))
        else $error("requests moved while clock enable low");
endmodule // timer_irq_checker

bind timer_irq_flag_mask timer_irq_checker i_timer_irq_checker (.*);

// [bench/tb_top.sv]
// Self-checking bench for the timer interrupt flag and mask block
`timescale 1ns/10ps
module tb_top;
    import timer_irq_pkg::*;
    logic              ref_clk_i = 1'b0, nrst_i = 1'b0, clk_en_i = 1'b1, ack_en = 1'b0;
    logic              awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
    logic [ADDR_W-1:0] awaddr_i = '0, araddr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0, rdata_o;
    logic [3:0]        wstrb_i = 4'hF;
    logic [11:0]       ev = '0;
    logic              t1_top_is_capture_i = 1'b0, t3_top_is_capture_i = 1'b0;
    logic              t1_capture_pin_evt_i, t3_capture_pin_evt_i, t1_reach_top_i, t3_reach_top_i;
    logic              t1_overflow_evt_i, t3_overflow_evt_i, awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
    logic [2:0]        t1_cmp_equal_i, t3_cmp_equal_i;
    logic [5:0]        t1_vector_ack_i, t3_vector_ack_i, t1_irq_req_o, t3_irq_req_o;
    logic [1:0]        bresp_o, rresp_o;
    int                mismatches = 0, cmp_count = 0;

    assign {t3_overflow_evt_i, t1_overflow_evt_i, t3_cmp_equal_i, t1_cmp_equal_i, t3_reach_top_i,
            t1_reach_top_i, t3_capture_pin_evt_i, t1_capture_pin_evt_i} = ev;
    timer_irq_flag_mask i_timer_irq_flag_mask (.*);
    cpu_core_model i_cpu_core_model (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ack_en_i(ack_en),
        .t1_irq_req_i(t1_irq_req_o), .t3_irq_req_i(t3_irq_req_o), .t1_vector_ack_o(t1_vector_ack_i),
        .t3_vector_ack_o(t3_vector_ack_i));

    initial forever #10 ref_clk_i = ~ref_clk_i;

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge ref_clk_i);
        awaddr_i <= a;
        wdata_i <= d;
        awvalid_i <= 1'b1;
        wvalid_i <= 1'b1;
        bready_i <= 1'b1;
        // Only the watchdog ends a wait for the response
        do
        begin
            @(posedge ref_clk_i);
            if (awready_o) awvalid_i <= 1'b0;
            if (wready_o) wvalid_i <= 1'b0;
        end
        while (!bvalid_o);
        bready_i <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp_o));
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge ref_clk_i);
        araddr_i <= a;
        arvalid_i <= 1'b1;
        rready_i <= 1'b1;
        do
        begin
            @(posedge ref_clk_i);
            if (arready_o) arvalid_i <= 1'b0;
        end
        while (!rvalid_o);
        rready_i <= 1'b0;
        chk("rdata", e, rdata_o);
        chk("rresp", 32'(er), 32'(rresp_o));
    endtask

    task pulse(input logic [11:0] v);
        @(posedge ref_clk_i);
        ev <= v;
        @(posedge ref_clk_i);
        ev <= '0;
    endtask

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task reset_values;
        rd(ADDR_T_FLAGS, 32'h0, RESP_OKAY);
        rd(ADDR_X_FLAGS, 32'h0, RESP_OKAY);
        rd(ADDR_X_EN, 32'h0, RESP_OKAY);
    endtask

    task event_set;
        pulse(12'h001);
        pulse(12'h002);
        pulse(12'h070);
        pulse(12'h380);
        pulse(12'hC00);
        rd(ADDR_T_FLAGS, 32'h3C, RESP_OKAY);
        rd(ADDR_X_FLAGS, 32'h3F, RESP_OKAY);
    endtask

    task w1c_clear;
        wr(ADDR_T_FLAGS, 32'h14, RESP_OKAY);
        rd(ADDR_T_FLAGS, 32'h28, RESP_OKAY);
        wr(ADDR_X_FLAGS, 32'h0, RESP_OKAY);
        rd(ADDR_X_FLAGS, 32'h3F, RESP_OKAY);
        wr(ADDR_X_FLAGS, 32'h03, RESP_OKAY);
        rd(ADDR_X_FLAGS, 32'h3C, RESP_OKAY);
    endtask

    task irq_mask_ack;
        wr(ADDR_T_EN, 32'h28, RESP_OKAY);
        wr(ADDR_X_EN, 32'h04, RESP_OKAY);
        chk("irq_o", 32'h0, 32'(irq_o));
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        chk("t3_req", 32'h04, 32'(t3_irq_req_o));
        chk("t1_req", 32'h28, 32'(t1_irq_req_o));
        wr(ADDR_X_EN, 32'h3F, RESP_OKAY);
        chk("t3_req", 32'h3C, 32'(t3_irq_req_o));
        ack_en <= 1'b1;
        repeat (40) @(posedge ref_clk_i);
        chk("irq_o", 32'h0, 32'(irq_o));
        ack_en <= 1'b0;
        rd(ADDR_T_FLAGS, 32'h0, RESP_OKAY);
        rd(ADDR_X_FLAGS, 32'h0, RESP_OKAY);
    endtask

    task top_capture;
        t1_top_is_capture_i <= 1'b1;
        t3_top_is_capture_i <= 1'b1;
        pulse(12'h003);
        rd(ADDR_X_FLAGS, 32'h0, RESP_OKAY);
        pulse(12'h00C);
        rd(ADDR_T_FLAGS, 32'h20, RESP_OKAY);
        rd(ADDR_X_FLAGS, 32'h20, RESP_OKAY);
    endtask

    task legacy_refuse;
        wr(ADDR_CTRL, 32'h3, RESP_OKAY);
        wr(ADDR_X_EN, 32'h0, RESP_SLVERR);
        rd(ADDR_X_EN, 32'h0, RESP_SLVERR);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        rd(ADDR_X_EN, 32'h3F, RESP_OKAY);
    endtask

    // Frozen event is lost, mid-run reset clears all, strobe-less write is ignored
    task freeze_and_reset;
        clk_en_i <= 1'b0;
        pulse(12'h010);
        clk_en_i <= 1'b1;
        rd(ADDR_T_FLAGS, 32'h20, RESP_OKAY);
        nrst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        chk("irq_o", 32'h0, 32'(irq_o));
        rd(ADDR_T_FLAGS, 32'h0, RESP_OKAY);
        rd(ADDR_X_EN, 32'h0, RESP_OKAY);
        wstrb_i <= 4'h0;
        wr(ADDR_T_EN, 32'h3F, RESP_OKAY);
        wstrb_i <= 4'hF;
        rd(ADDR_T_EN, 32'h0, RESP_OKAY);
    endtask

    initial
    begin
        #100000;
        mismatches++;
        tally_and_finish();
    end

    initial
    begin
        repeat (16) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        reset_values();
        event_set();
        w1c_clear();
        irq_mask_ack();
        top_capture();
        legacy_refuse();
        freeze_and_reset();
        tally_and_finish();
    end
endmodule // tb_top
